// ==== design/wake_interrupt_control.sv ====
// Wake-up and interrupt dispatch for a small 8-bit controller core.
// Assumes event pulses from peripherals on the core clock, pins asynchronous, and a classic Wishbone master.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "wake_ctl_regs.svh"

// Operation
// - Wake only out of sleep and idle
// - Conversion running keeps slow, main clocks alive
// - Sleep halts oscillator, tick counter, aux timers
// - Sleep, both port enables clear: nothing happens
// - Normal, port irq enable clear: no interrupt
// - Sleep, irq enable only: flag, no wake
// - Sleep, wake enable only: wake, next instruction
// - Both enables, globals off: wake, flag, next
// - Both enables, globals on: wake, flag, vector
// - Normal port change, enabled: flag, vector 0x06
// - Tick overflow, globals off: flag, next instruction
// - Tick overflow, globals on: flag, vector 0x09
// - External pin, globals off: flag, next instruction
// - Sleep without conversion enables stops converter
// - Wake handlers at 0x06, 0x0F, 0x0C, 0x1B
module wake_interrupt_control import wake_ctl_pkg::*; #(
	parameter int PORT_WIDTH = 8, // Number of port pins watched for change
	parameter logic [7:0] EXT_PIN_VECTOR = `EXT_PIN_VECTOR_DEFAULT // Handler address of the external pin
) (
	input wire logic core_clk_in, // Core clock, 200 MHz
	input wire logic reset_n_in, // Asynchronous reset, active low
	input wire logic wb_cyc_in, // Wishbone cycle
	input wire logic wb_stb_in, // Wishbone strobe
	input wire logic wb_we_in, // Wishbone write enable
	input wire logic [7:0] wb_adr_in, // Wishbone byte address
	input wire logic [3:0] wb_sel_in, // Wishbone byte selects
	input wire logic [31:0] wb_dat_in, // Wishbone write data
	output logic [31:0] wb_dat_out, // Wishbone read data
	output logic wb_ack_out, // Wishbone acknowledge
	input wire logic [PORT_WIDTH-1:0] port_pins_in, // Port pins, asynchronous
	input wire logic ext_pin_in, // External interrupt pin, asynchronous, falling edge
	input wire periph_event_t periph_event_in, // Peripheral event pulses
	input wire core_op_t core_op_in, // Instruction strobes from the core
	input wire logic irq_taken_in, // Core has branched to the vector
	input wire logic watchdog_timeout_in, // Watchdog time-out pulse
	input wire logic low_voltage_reset_in, // Low-voltage reset pulse
	output logic irq_req_out, // Interrupt request to the core
	output logic [7:0] irq_vector_out, // Handler address
	output logic wake_out, // One-cycle wake pulse, core resumes
	output logic core_halted_out, // Core stopped in sleep or idle
	output clock_run_t clock_run_out, // Clock and timer run controls
	output logic converter_run_out, // Converter run bit
	output logic device_reset_out // One-cycle device reset pulse
);

	// Refuse pin counts that the change detector was not sized for
	if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : g_port_width_check
		$error("PORT_WIDTH must be 1 to 8");
	end

	op_mode_t mode_q; // Present operating mode
	logic [7:0] wake_en_q; // Wake enable bank
	logic [7:0] pend_q; // Pending flag bank
	logic [7:0] irq_en_q; // Interrupt enable bank
	logic conv_run_q; // Converter run bit
	logic green_req_q; // Software request for green mode
	logic global_irq_q; // Global interrupt enable
	logic [PORT_WIDTH-1:0] port_sync1_q; // Port synchroniser, first stage
	logic [PORT_WIDTH-1:0] port_sync2_q; // Port synchroniser, second stage
	logic [PORT_WIDTH-1:0] port_last_q; // Previous synchronised port level
	logic ext_sync1_q; // External pin synchroniser, first stage
	logic ext_sync2_q; // External pin synchroniser, second stage
	logic ext_last_q; // Previous synchronised external level
	logic [31:0] rd_data_q; // Registered read data
	logic ack_q; // Registered acknowledge
	logic irq_req_q; // Registered interrupt request
	logic [7:0] vector_q; // Registered vector
	logic wake_q; // Registered wake pulse
	logic halted_q; // Registered halted flag
	clock_run_t clock_run_q; // Registered run controls
	logic dev_reset_q; // Registered reset pulse

	logic bus_req; // New bus request this cycle
	logic bus_wr; // Write taken this cycle
	logic [7:0] wr_byte; // Low byte of write data, whichever lanes are selected
	logic wr_lane0; // Low byte lane selected
	logic dev_reset; // Device reset event
	logic [7:0] events; // Raw events in flag layout
	logic [7:0] flag_set; // Flags set this cycle
	logic [7:0] flag_clr; // Flags cleared by software
	logic port_change; // Any port pin changed
	logic ext_fall; // External pin falling edge
	logic sleeping; // Mode is sleep
	logic wake_evt; // A wake condition in sleep or idle
	logic [7:0] active; // Enabled pending flags
	logic [7:0] vec_sel; // Vector of highest-priority active flag

	assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;
	assign bus_wr = bus_req && wb_we_in;
	assign wr_lane0 = wb_sel_in[0];
	assign wr_byte = wb_dat_in[7:0];
	assign dev_reset = watchdog_timeout_in || low_voltage_reset_in;
	assign sleeping = (mode_q == MODE_SLEEP);
	assign port_change = |(port_sync2_q ^ port_last_q);
	assign ext_fall = ext_last_q && !ext_sync2_q;

	// Synchronise the port pins and external pin; only the second stage is read
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			port_sync1_q <= '0;
			port_sync2_q <= '0;
			port_last_q <= '0;
			ext_sync1_q <= 1'b1;
			ext_sync2_q <= 1'b1;
			ext_last_q <= 1'b1;
		end else begin
			port_sync1_q <= port_pins_in;
			port_sync2_q <= port_sync1_q;
			port_last_q <= port_sync2_q;
			ext_sync1_q <= ext_pin_in;
			ext_sync2_q <= ext_sync1_q;
			ext_last_q <= ext_sync2_q;
		end
	end

	// Gather events into the flag layout, dropping those that cannot occur in the mode
	always_comb begin
		events = '0;
		// Tick counter and aux timers are halted in sleep, so their events do not count
		events[`TICK_OVERFLOW_BIT] = periph_event_in.tick_overflow && !sleeping;
		events[`PERIOD_MATCH_BIT] = periph_event_in.period_match && !sleeping;
		// External pin has no effect in sleep
		events[`EXT_PIN_BIT] = ext_fall && !sleeping;
		events[`PORT_CHANGE_BIT] = port_change;
		// Conversion done is not an interrupt source in green mode
		events[`CONV_DONE_BIT] = periph_event_in.conv_done && (mode_q != MODE_GREEN);
		events[`LOW_VOLTAGE_BIT] = periph_event_in.low_voltage;
		events[`COMPARATOR_BIT] = periph_event_in.comparator;
	end

	// A flag is set only where its interrupt enable is set
	assign flag_set = events & irq_en_q;
	// Write one to clear over the bus
	assign flag_clr = (bus_wr && wr_lane0 && wb_adr_in == `PENDING_FLAG_BANK_OFS) ? wr_byte : '0;

	// Wake condition: only out of sleep or idle
	always_comb begin
		wake_evt = 1'b0;
		if (mode_q == MODE_SLEEP || mode_q == MODE_IDLE) begin
			// Sources with their own wake enable, honoured in sleep and idle
			wake_evt = (events[`PORT_CHANGE_BIT] && wake_en_q[`PORT_CHANGE_WAKE_BIT])
				|| (events[`CONV_DONE_BIT] && wake_en_q[`CONV_DONE_WAKE_BIT])
				|| (events[`COMPARATOR_BIT] && wake_en_q[`COMPARATOR_WAKE_BIT])
				|| (events[`LOW_VOLTAGE_BIT] && wake_en_q[`LOW_VOLTAGE_WAKE_BIT]);
			// Idle also wakes on enabled tick, external and period match events
			if (mode_q == MODE_IDLE) begin
				wake_evt = wake_evt || |(flag_set & ((8'h01 << `TICK_OVERFLOW_BIT)
					| (8'h01 << `EXT_PIN_BIT) | (8'h01 << `PERIOD_MATCH_BIT)));
			end
		end
	end

	// Operating mode: sleep and idle entered by instruction, left by wake
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_q <= MODE_NORMAL;
		end else if (dev_reset) begin
			mode_q <= MODE_NORMAL;
		end else begin
			unique case (mode_q)
				MODE_NORMAL, MODE_GREEN: begin
					if (core_op_in.sleep_op) begin
						mode_q <= MODE_SLEEP;
					end else if (core_op_in.idle_op) begin
						mode_q <= MODE_IDLE;
					end else begin
						mode_q <= green_req_q ? MODE_GREEN : MODE_NORMAL;
					end
				end
				MODE_IDLE, MODE_SLEEP: begin
					// Return to the running mode that software selected
					if (wake_evt) begin
						mode_q <= green_req_q ? MODE_GREEN : MODE_NORMAL;
					end
				end
			endcase
		end
	end

	// Pending flags: hardware set wins over software clear
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_q <= `BANK_RESET;
		end else if (dev_reset) begin
			pend_q <= `BANK_RESET;
		end else begin
			pend_q <= (pend_q & ~flag_clr) | flag_set;
		end
	end

	// Global interrupt enable from the on and off instructions, dropped on entry to a handler
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			global_irq_q <= 1'b0;
		end else if (dev_reset) begin
			global_irq_q <= 1'b0;
		end else if (core_op_in.global_irq_off_op || irq_taken_in) begin
			global_irq_q <= 1'b0;
		end else if (core_op_in.global_irq_on_op) begin
			global_irq_q <= 1'b1;
		end
	end

	// Software registers: wake enables, interrupt enables, green request
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wake_en_q <= `BANK_RESET;
			irq_en_q <= `BANK_RESET;
			green_req_q <= 1'b0;
		end else if (dev_reset) begin
			wake_en_q <= `BANK_RESET;
			irq_en_q <= `BANK_RESET;
			green_req_q <= 1'b0;
		end else if (bus_wr && wr_lane0) begin
			// Only the low byte lane carries register bits
			unique case (wb_adr_in)
				`WAKE_ENABLE_BANK_OFS: begin
					wake_en_q <= wr_byte;
				end
				`IRQ_ENABLE_BANK_OFS: begin
					irq_en_q <= wr_byte;
				end
				`MODE_STATUS_OFS: begin
					green_req_q <= wr_byte[`GREEN_REQ_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Converter run bit: set by software, cleared at completion or by a sleep without conversion enables
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			conv_run_q <= 1'b0;
		end else if (dev_reset) begin
			conv_run_q <= 1'b0;
		end else if (core_op_in.sleep_op && (mode_q == MODE_NORMAL || mode_q == MODE_GREEN)
			&& !wake_en_q[`CONV_DONE_WAKE_BIT]
			&& !irq_en_q[`CONV_DONE_BIT]) begin
			conv_run_q <= 1'b0;
		end else if (periph_event_in.conv_done) begin
			conv_run_q <= 1'b0;
		end else if (bus_wr && wr_lane0 && wb_adr_in == `CONVERTER_CONTROL_BANK_OFS) begin
			conv_run_q <= wr_byte[`CONVERTER_RUN_BIT];
		end
	end

	// Enabled pending flags and fixed priority by handler address
	assign active = pend_q & irq_en_q;
	always_comb begin
		vec_sel = `PORT_CHANGE_VECTOR;
		if (active[`EXT_PIN_BIT]) begin
			vec_sel = EXT_PIN_VECTOR;
		end else if (active[`PORT_CHANGE_BIT]) begin
			vec_sel = `PORT_CHANGE_VECTOR;
		end else if (active[`TICK_OVERFLOW_BIT]) begin
			vec_sel = `TICK_OVERFLOW_VECTOR;
		end else if (active[`CONV_DONE_BIT]) begin
			vec_sel = `CONV_DONE_VECTOR;
		end else if (active[`COMPARATOR_BIT]) begin
			vec_sel = `COMPARATOR_VECTOR;
		end else if (active[`PERIOD_MATCH_BIT]) begin
			vec_sel = `PERIOD_MATCH_VECTOR;
		end else if (active[`LOW_VOLTAGE_BIT]) begin
			vec_sel = `LOW_VOLTAGE_VECTOR;
		end
	end

	// Interrupt request: only while running and globally enabled; otherwise the core runs on
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_req_q <= 1'b0;
			vector_q <= `PORT_CHANGE_VECTOR;
		end else begin
			// Halted core takes the branch only after its wake has been seen
			irq_req_q <= !dev_reset && !irq_taken_in && global_irq_q && (|active)
				&& (mode_q == MODE_NORMAL || mode_q == MODE_GREEN);
			vector_q <= vec_sel;
		end
	end

	// Wake pulse, halted flag and reset pulse
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wake_q <= 1'b0;
			halted_q <= 1'b0;
			dev_reset_q <= 1'b0;
		end else begin
			wake_q <= wake_evt && !dev_reset;
			halted_q <= (mode_q == MODE_SLEEP || mode_q == MODE_IDLE) && !wake_evt && !dev_reset;
			dev_reset_q <= dev_reset;
		end
	end

	// Clock and timer run controls
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_run_q <= '1;
		end else begin
			clock_run_q.oscillator <= !sleeping;
			clock_run_q.tick_counter <= !sleeping;
			clock_run_q.aux_timers <= !sleeping;
			clock_run_q.slow_clock_source <= !sleeping || conv_run_q;
			clock_run_q.main_clock_source <= (mode_q == MODE_NORMAL) || conv_run_q;
		end
	end

	// Wishbone slave: one wait state, registered data, zero for unmapped addresses
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_q <= 1'b0;
			rd_data_q <= `WORD_ZERO;
		end else begin
			ack_q <= bus_req;
			rd_data_q <= `WORD_ZERO;
			if (bus_req && !wb_we_in) begin
				unique case (wb_adr_in)
					`WAKE_ENABLE_BANK_OFS: begin
						rd_data_q[7:0] <= wake_en_q;
					end
					`PENDING_FLAG_BANK_OFS: begin
						rd_data_q[7:0] <= pend_q;
					end
					`IRQ_ENABLE_BANK_OFS: begin
						rd_data_q[7:0] <= irq_en_q;
					end
					`CONVERTER_CONTROL_BANK_OFS: begin
						rd_data_q[`CONVERTER_RUN_BIT] <= conv_run_q;
					end
					`MODE_STATUS_OFS: begin
						rd_data_q[`GREEN_REQ_BIT] <= green_req_q;
						rd_data_q[`GLOBAL_IRQ_BIT] <= global_irq_q;
						rd_data_q[`MODE_MSB:`MODE_LSB] <= mode_q;
					end
					default: begin
					end
				endcase
			end
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = rd_data_q;
	assign irq_req_out = irq_req_q;
	assign irq_vector_out = vector_q;
	assign wake_out = wake_q;
	assign core_halted_out = halted_q;
	assign clock_run_out = clock_run_q;
	assign converter_run_out = conv_run_q;
	assign device_reset_out = dev_reset_q;

endmodule : wake_interrupt_control

// ==== design/wake_ctl_regs.svh ====
// Register offsets, bit positions, vectors and reset values of the wake and interrupt control.
// Assumes a 32-bit classic Wishbone slave with one aligned word per register.
`ifndef WAKE_CTL_REGS_SVH
`define WAKE_CTL_REGS_SVH

// Byte offsets of the registers
`define WAKE_ENABLE_BANK_OFS 8'h00
`define PENDING_FLAG_BANK_OFS 8'h04
`define IRQ_ENABLE_BANK_OFS 8'h08
`define CONVERTER_CONTROL_BANK_OFS 8'h0C
`define MODE_STATUS_OFS 8'h10

// Wake enable bank fields
`define PORT_CHANGE_WAKE_BIT 1
`define COMPARATOR_WAKE_BIT 2
`define CONV_DONE_WAKE_BIT 3
`define LOW_VOLTAGE_WAKE_BIT 4

// Pending flag bank and interrupt enable bank fields (shared layout)
`define TICK_OVERFLOW_BIT 0
`define PORT_CHANGE_BIT 1
`define EXT_PIN_BIT 2
`define CONV_DONE_BIT 3
`define PERIOD_MATCH_BIT 4
`define LOW_VOLTAGE_BIT 5
`define COMPARATOR_BIT 7

// Converter control bank fields
`define CONVERTER_RUN_BIT 0

// Mode and status register fields
`define GREEN_REQ_BIT 0
`define GLOBAL_IRQ_BIT 1
`define MODE_LSB 4
`define MODE_MSB 5

// Reset values
`define BANK_RESET 8'h00
`define WORD_ZERO 32'h0000_0000

// Handler addresses
`define TICK_OVERFLOW_VECTOR 8'h09
`define PORT_CHANGE_VECTOR 8'h06
`define CONV_DONE_VECTOR 8'h0C
`define COMPARATOR_VECTOR 8'h0F
`define PERIOD_MATCH_VECTOR 8'h12
`define LOW_VOLTAGE_VECTOR 8'h1B
`define EXT_PIN_VECTOR_DEFAULT 8'h03

`endif

// ==== design/wake_ctl_pkg.sv ====
// Types shared by the wake and interrupt control.
// Assumes the constants header is included by the files that need offsets.
package wake_ctl_pkg;

	// Operating mode of the core
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_GREEN = 2'b01,
		MODE_IDLE = 2'b10,
		MODE_SLEEP = 2'b11
	} op_mode_t;

	// Same-clock event pulses from the peripherals
	typedef struct packed {
		logic tick_overflow;
		logic conv_done;
		logic comparator;
		logic period_match;
		logic low_voltage;
	} periph_event_t;

	// Instruction strobes decoded by the core
	typedef struct packed {
		logic global_irq_on_op;
		logic global_irq_off_op;
		logic sleep_op;
		logic idle_op;
	} core_op_t;

	// Clock and timer run controls
	typedef struct packed {
		logic oscillator;
		logic slow_clock_source;
		logic main_clock_source;
		logic tick_counter;
		logic aux_timers;
	} clock_run_t;

endpackage : wake_ctl_pkg

// ==== bench/wake_interrupt_control_monitor.sv ====
// Checker for the wake and interrupt control, watching the top-level ports only.
// Assumes one core clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`include "wake_ctl_regs.svh"
module wake_interrupt_control_monitor import wake_ctl_pkg::*; (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic wb_cyc_in, // Bus cycle
	input wire logic wb_stb_in, // Bus strobe
	input wire logic wb_ack_out, // Bus acknowledge
	input wire logic irq_taken_in, // Core took the vector
	input wire logic watchdog_timeout_in, // Watchdog pulse
	input wire logic low_voltage_reset_in, // Low-voltage reset pulse
	input wire logic irq_req_out, // Interrupt request
	input wire logic [7:0] irq_vector_out, // Handler address
	input wire logic wake_out, // Wake pulse
	input wire logic core_halted_out, // Core halted
	input wire clock_run_t clock_run_out, // Clock run controls
	input wire logic converter_run_out, // Converter run bit
	input wire logic device_reset_out // Device reset pulse
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// A fresh request gets a one-cycle acknowledge on the next edge
	property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("bus acknowledge late or too long");
	// Wake comes only out of a halted core and ends the halt
	property p_wake_src; wake_out |-> $past(core_halted_out) && !core_halted_out; endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake without halted core");
	// Wake is a single pulse
	property p_wake_pulse; wake_out |=> !wake_out; endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
	// A running conversion keeps both clock sources alive
	property p_conv_clk; converter_run_out && $past(converter_run_out) |->
		clock_run_out.slow_clock_source && clock_run_out.main_clock_source; endproperty
	a_conv_clk: assert property (p_conv_clk) else $error("clock stopped during conversion");
	// Oscillator off means tick counter and timers off too
	property p_sleep_halt; !clock_run_out.oscillator |-> !clock_run_out.tick_counter && !clock_run_out.aux_timers;
	endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("timer running with oscillator off");
	// Watchdog time-out resets the device next cycle
	property p_reset_wd; watchdog_timeout_in |=> device_reset_out ##1 !device_reset_out; endproperty
	a_reset_wd: assert property (p_reset_wd) else $error("no reset after watchdog");
	// Low-voltage reset resets the device next cycle
	property p_reset_lv; low_voltage_reset_in |=> device_reset_out; endproperty
	a_reset_lv: assert property (p_reset_lv) else $error("no reset after low voltage");
	// Device reset only follows one of its two causes
	property p_reset_cause; device_reset_out |-> $past(watchdog_timeout_in) || $past(low_voltage_reset_in); endproperty
	a_reset_cause: assert property (p_reset_cause) else $error("device reset without cause");
	// Taking the vector withdraws the request
	property p_taken; irq_req_out && irq_taken_in |=> !irq_req_out; endproperty
	a_taken: assert property (p_taken) else $error("request held after vector taken");
	// A request always names one of the handler addresses
	property p_vec; irq_req_out |-> irq_vector_out inside {`PORT_CHANGE_VECTOR, `TICK_OVERFLOW_VECTOR,
		`CONV_DONE_VECTOR, `COMPARATOR_VECTOR, `PERIOD_MATCH_VECTOR, `LOW_VOLTAGE_VECTOR, `EXT_PIN_VECTOR_DEFAULT};
	endproperty
	a_vec: assert property (p_vec) else $error("unknown handler address");
endmodule : wake_interrupt_control_monitor

bind wake_interrupt_control wake_interrupt_control_monitor mon (.core_clk_in(core_clk_in),
	.reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
	.irq_taken_in(irq_taken_in), .watchdog_timeout_in(watchdog_timeout_in),
	.low_voltage_reset_in(low_voltage_reset_in), .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out),
	.wake_out(wake_out), .core_halted_out(core_halted_out), .clock_run_out(clock_run_out),
	.converter_run_out(converter_run_out), .device_reset_out(device_reset_out));

// ==== bench/test_wake_interrupt_control.sv ====
// Self-checking bench for the wake and interrupt control.
// Assumes the package and the constants header are on the compile path.
`timescale 1ns/100ps
`include "wake_ctl_regs.svh"
module test_wake_interrupt_control import wake_ctl_pkg::*; ;
	// Case row: mode, source (0 port, 1 tick, 2 ext), enables, expected wake, flag, request, vector
	typedef struct packed {
		logic [1:0] md;
		logic [1:0] src;
		logic we;
		logic ie;
		logic gl;
		logic wk;
		logic fl;
		logic rq;
		logic [7:0] vc;
	} row_t;
	row_t rows [12] = '{
		'{2'h3, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00},
		'{2'h3, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00},
		'{2'h3, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 8'h00},
		'{2'h3, 2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00},
		'{2'h3, 2'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'h06},
		'{2'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 8'h00},
		'{2'h0, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 8'h06},
		'{2'h0, 2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00},
		'{2'h0, 2'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 8'h09},
		'{2'h0, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00},
		'{2'h1, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00},
		'{2'h2, 2'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00}};
	logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ext = 1'h1; // Inputs
	logic taken = 1'h0, wdog = 1'h0, lvr = 1'h0; // Core and reset inputs
	logic [7:0] adr = 8'h00, pins = 8'h00; // Address and port pins
	logic [3:0] sel = 4'h0; // Byte selects
	logic [31:0] wdat = 32'h0000_0000, rdat, rd; // Bus data
	periph_event_t pev = '0; // Peripheral pulses
	core_op_t cop = '0; // Instruction strobes
	logic ack, irq, wake, halted, crun, dres, woke; // Outputs and wake seen
	logic [7:0] vec; // Handler address
	clock_run_t cr; // Clock run controls
	row_t r; // Current row
	int miscompares = 0, samples_checked = 0, fb; // Counters and flag bit
	wake_interrupt_control uut (.core_clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.port_pins_in(pins), .ext_pin_in(ext), .periph_event_in(pev), .core_op_in(cop), .irq_taken_in(taken),
		.watchdog_timeout_in(wdog), .low_voltage_reset_in(lvr), .irq_req_out(irq), .irq_vector_out(vec),
		.wake_out(wake), .core_halted_out(halted), .clock_run_out(cr), .converter_run_out(crun),
		.device_reset_out(dres));
	// Clock at 200 MHz
	initial forever #2.5 clk = ~clk;
	// Compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Print counts and verdict, then stop
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	// One classic Wishbone cycle; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		if (ack !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
	endtask : bus
	// One-cycle instruction strobe
	task automatic op(input core_op_t v);
		@(posedge clk);
		cop <= v;
		@(posedge clk);
		cop <= '0;
	endtask : op
	// One-cycle peripheral pulse
	task automatic ev(input periph_event_t v);
		@(posedge clk);
		pev <= v;
		@(posedge clk);
		pev <= '0;
	endtask : ev
	// Reset the device through the watchdog input
	task automatic dog;
		@(posedge clk);
		wdog <= 1'h1;
		@(posedge clk);
		wdog <= 1'h0;
	endtask : dog
	// Watch for a wake pulse over a window
	task automatic watch(input int n);
		woke = 1'h0;
		repeat (n) begin
			@(posedge clk);
			if (wake === 1'b1) woke = 1'h1;
		end
	endtask : watch
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			bus(0, 8'(i * 4), 32'h0000_0000);
			check("reset_reg", rd, 32'h0000_0000);
		end
		check("reset_clocks", 32'(cr), 32'h0000_001F);
		// Table of event cases, each after a device reset
		foreach (rows[i]) begin
			r = rows[i];
			fb = (r.src == 0) ? `PORT_CHANGE_BIT : (r.src == 1) ? `TICK_OVERFLOW_BIT : `EXT_PIN_BIT;
			dog();
			bus(1'h1, `WAKE_ENABLE_BANK_OFS, 32'(r.we) << `PORT_CHANGE_WAKE_BIT);
			bus(1'h1, `IRQ_ENABLE_BANK_OFS, 32'(r.ie) << fb);
			if (r.gl) op(4'h8);
			if (r.md == 2'h1) bus(1'h1, `MODE_STATUS_OFS, 32'h0000_0001);
			if (r.md == 2'h2) op(4'h1);
			if (r.md == 2'h3) op(4'h2);
			bus(1'h0, `MODE_STATUS_OFS, 32'h0000_0000);
			check("mode", 32'(rd[`MODE_MSB:`MODE_LSB]), 32'(r.md));
			@(posedge clk);
			if (r.src == 0) pins[0] <= ~pins[0];
			if (r.src == 2) ext <= 1'h0;
			if (r.src == 1) ev(5'h10);
			watch(8);
			check("wake", 32'(woke), 32'(r.wk));
			check("irq_req", 32'(irq), 32'(r.rq));
			if (r.rq) check("vector", 32'(vec), 32'(r.vc));
			bus(1'h0, `PENDING_FLAG_BANK_OFS, 32'h0000_0000);
			check("flags", rd, 32'(r.fl) << fb);
			ext <= 1'h1;
			if (r.rq) begin
				@(posedge clk);
				taken <= 1'h1;
				@(posedge clk);
				taken <= 1'h0;
				repeat (2) @(posedge clk);
				check("irq_taken", 32'(irq), 32'h0000_0000);
			end
		end
		// Sleep with no conversion enables stops the converter and all clocks
		dog();
		bus(1'h1, `CONVERTER_CONTROL_BANK_OFS, 32'h0000_0001);
		check("run_set", 32'(crun), 32'h0000_0001);
		op(4'h2);
		repeat (2) @(posedge clk);
		check("run_cleared", 32'(crun), 32'h0000_0000);
		check("sleep_clocks", 32'(cr), 32'h0000_0000);
		// Conversion wake with globals on keeps clocks and vectors to its handler
		dog();
		bus(1'h1, `WAKE_ENABLE_BANK_OFS, 32'h0000_0008);
		bus(1'h1, `IRQ_ENABLE_BANK_OFS, 32'h0000_0008);
		bus(1'h1, `CONVERTER_CONTROL_BANK_OFS, 32'h0000_0001);
		op(4'h8);
		op(4'h2);
		repeat (3) @(posedge clk);
		check("conv_clocks", 32'(cr), 32'h0000_000C);
		check("conv_run", 32'(crun), 32'h0000_0001);
		check("halted", 32'(halted), 32'h0000_0001);
		ev(5'h08);
		watch(6);
		check("conv_wake", 32'(woke), 32'h0000_0001);
		check("conv_vector", 32'(vec), 32'h0000_000C);
		check("conv_irq", 32'(irq), 32'h0000_0001);
		// Low-voltage reset pulses the device reset and clears the banks; unmapped address reads zero
		@(posedge clk);
		lvr <= 1'h1;
		@(posedge clk);
		lvr <= 1'h0;
		@(posedge clk);
		check("dev_reset", 32'(dres), 32'h0000_0001);
		bus(1'h0, `WAKE_ENABLE_BANK_OFS, 32'h0000_0000);
		check("lv_reset", rd, 32'h0000_0000);
		bus(1'h0, 8'h20, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		give_verdict();
	end
endmodule : test_wake_interrupt_control
